// [pulse_sequencer.sv]
/*
 * Gated pulse / burst / pattern sequencer with external-width mode,
 * trigger marker and strobe marker, behind a simple register port.
 * Assumes all inputs except the gate and reset_n_in are synchronous to sys_clk_in.
 */
// Our own choices: the plain strobed port and the register addresses.
// Summary of operation
// - gated pulse: start on gate rise; period running at gate fall is last
// - pll or external timebase: first period 1 to 2 periods after gate
// - every period is aligned to ticks of the selected timebase
// - pulse and burst modes emit one trigger marker per period
// - gated burst repeats bursts; burst running at gate fall is last
// - burst strobe rises at first period, falls at last period start
// - gated pattern repeats pattern; pattern at gate fall is last
// - pattern mode emits one trigger marker per bit period
// - pattern strobe level per bit comes from programmed strobe bits
// - external width: output follows gate level, no timebase involved
// - level arming with manual origin is rejected and flagged
// - continuous mode ignores edge select and arming origin
// - pulse mode refuses pll as arming origin
// - bus address 0..30, default 10, takes effect only on restart
// - gated mode: gate rise starts output, unit running at gate fall is the last
// - pattern strobe is nrz, held for the whole bit period
// - pll cannot be both arming origin and timebase
`timescale 1ns/1ps
module pulse_sequencer #(
    parameter int CNT_W = 16,
    parameter int PAT_W = 32
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [seq_pkg::ADDR_W-1:0] addr_in,
    input wire logic [seq_pkg::DATA_W-1:0] wr_data_in,
    input wire logic wr_strobe_in,
    input wire logic rd_strobe_in,
    output logic [seq_pkg::DATA_W-1:0] rd_data_out,
    input wire logic external_gate_input_in,
    input wire logic external_period_clock_in,
    output logic pulse_out,
    output logic trig_marker_out,
    output logic strobe_out,
    output logic [4:0] bus_primary_address_out
);
    import seq_pkg::*;

    localparam int IDX_W = $clog2(PAT_W);

    typedef enum logic [1:0] {S_IDLE, S_ALIGN, S_RUN} state_type;

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic cfg_legal(input ctrl_type c);
        logic ok;
        ok = (c.trig_mode != trig_type'(2'h3));
        ok = ok && (c.arming_origin_select != origin_type'(2'h3));
        ok = ok && (c.timebase_select != timebase_type'(2'h3));
        ok = ok && !(c.trig_mode == TRIG_LEVEL &&
                     c.arming_origin_select == ORG_MANUAL);
        ok = ok && !(c.mode == MODE_PULSE &&
                     c.arming_origin_select == ORG_PLL);
        ok = ok && !(c.arming_origin_select == ORG_PLL &&
                     c.timebase_select == TB_PLL);
        return ok;
    endfunction

    function automatic logic [CNT_W-1:0] unit_last(input mode_type m,
            input logic [CNT_W-1:0] burst, input logic [CNT_W-1:0] plen);
        logic [CNT_W-1:0] r;
        r = '0;
        if (m == MODE_BURST && burst != '0) begin
            r = burst - 1'b1;
        end else if (m == MODE_PATTERN && plen != '0) begin
            r = (plen > CNT_W'(PAT_W)) ? CNT_W'(PAT_W - 1) : plen - 1'b1;
        end
        return r;
    endfunction

    function automatic logic [CNT_W-1:0] tick_limit(
            input logic [CNT_W-1:0] p);
        return (p == '0) ? '0 : p - 1'b1;
    endfunction

    // ************************************************************
    // reset release
    // ************************************************************
    logic [1:0] rst_pipe_ff;
    logic rst_n;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_pipe_ff <= 2'h0;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_ff[1];

    // ************************************************************
    // registers
    // ************************************************************
    ctrl_type ctrl_ff;
    logic [CNT_W-1:0] period_ff, pll_period_ff, width_ff, burst_ff;
    logic [CNT_W-1:0] pat_len_ff;
    logic [PAT_W-1:0] pat_bits_ff, strobe_bits_ff;
    logic [4:0] pending_addr_ff, active_addr_ff;
    logic cfg_err_ff, addr_err_ff;
    logic [DATA_W-1:0] rd_data_ff;
    logic wr_ctrl, wr_addr, wr_status, restart;
    logic cfg_reject, addr_reject;
    ctrl_type wr_ctrl_val;
    state_type state_ff, nxt_state;
    logic gate_lvl;

    assign wr_ctrl_val = ctrl_type'(wr_data_in[CTRL_W-1:0]);
    assign wr_ctrl = wr_strobe_in && addr_in == OFS_CTRL;
    assign wr_addr = wr_strobe_in && addr_in == OFS_ADDR;
    assign wr_status = wr_strobe_in && addr_in == OFS_STATUS;
    assign restart = wr_strobe_in && addr_in == OFS_RESTART &&
                     wr_data_in[RESTART_BIT];
    assign cfg_reject = wr_ctrl && !cfg_legal(wr_ctrl_val);
    assign addr_reject = wr_addr && wr_data_in[4:0] > ADDR_MAX;

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= ctrl_type'(CTRL_RESET);
            period_ff <= CNT_W'(PERIOD_RESET);
            pll_period_ff <= CNT_W'(PERIOD_RESET);
            width_ff <= CNT_W'(WIDTH_RESET);
            burst_ff <= CNT_W'(BURST_RESET);
            pat_len_ff <= CNT_W'(PAT_LEN_RESET);
            pat_bits_ff <= '0;
            strobe_bits_ff <= '0;
        end else if (wr_strobe_in) begin
            unique case (addr_in)
                OFS_CTRL: if (!cfg_reject) ctrl_ff <= wr_ctrl_val;
                OFS_PERIOD: period_ff <= wr_data_in[CNT_W-1:0];
                OFS_PLL_PERIOD: pll_period_ff <= wr_data_in[CNT_W-1:0];
                OFS_WIDTH: width_ff <= wr_data_in[CNT_W-1:0];
                OFS_BURST: burst_ff <= wr_data_in[CNT_W-1:0];
                OFS_PAT_LEN: pat_len_ff <= wr_data_in[CNT_W-1:0];
                OFS_PAT_BITS: pat_bits_ff <= wr_data_in[PAT_W-1:0];
                OFS_STROBE_BITS: strobe_bits_ff <= wr_data_in[PAT_W-1:0];
                default: ;
            endcase
        end
    end

    // pending address is only copied to the live one on restart
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pending_addr_ff <= ADDR_DEFAULT;
            active_addr_ff <= ADDR_DEFAULT;
        end else begin
            if (wr_addr && !addr_reject) begin
                pending_addr_ff <= wr_data_in[4:0];
            end
            if (restart) begin
                active_addr_ff <= pending_addr_ff;
            end
        end
    end

    // error flags: write one to clear, a new error in the same cycle wins
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cfg_err_ff <= 1'b0;
            addr_err_ff <= 1'b0;
        end else begin
            cfg_err_ff <= cfg_reject ||
                (cfg_err_ff && !(wr_status && wr_data_in[ST_CFG_ERR]));
            addr_err_ff <= addr_reject ||
                (addr_err_ff && !(wr_status && wr_data_in[ST_ADDR_ERR]));
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= '0;
            if (rd_strobe_in) begin
                unique case (addr_in)
                    OFS_CTRL: rd_data_ff <= DATA_W'(ctrl_ff);
                    OFS_PERIOD: rd_data_ff <= DATA_W'(period_ff);
                    OFS_PLL_PERIOD: rd_data_ff <= DATA_W'(pll_period_ff);
                    OFS_WIDTH: rd_data_ff <= DATA_W'(width_ff);
                    OFS_BURST: rd_data_ff <= DATA_W'(burst_ff);
                    OFS_PAT_LEN: rd_data_ff <= DATA_W'(pat_len_ff);
                    OFS_PAT_BITS: rd_data_ff <= DATA_W'(pat_bits_ff);
                    OFS_STROBE_BITS: rd_data_ff <= DATA_W'(strobe_bits_ff);
                    OFS_ADDR: begin
                        rd_data_ff[4:0] <= pending_addr_ff;
                        rd_data_ff[ADDR_ACTIVE_LSB +: 5] <= active_addr_ff;
                    end
                    OFS_STATUS: begin
                        rd_data_ff[ST_CFG_ERR] <= cfg_err_ff;
                        rd_data_ff[ST_ADDR_ERR] <= addr_err_ff;
                        rd_data_ff[ST_RUNNING] <= state_ff != S_IDLE;
                        rd_data_ff[ST_GATE] <= gate_lvl;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ************************************************************
    // gate and timebase
    // ************************************************************
    logic gate_d_ff, gate_rise, ext_clk_d_ff;
    logic [CNT_W-1:0] osc_cnt_ff, pll_cnt_ff;
    logic osc_tick, pll_tick, tick, osc_restart;
    logic run_req, keep_going;

    gate_synchronizer u_gate_sync (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .async_in(external_gate_input_in),
        .sync_out(gate_lvl)
    );

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            gate_d_ff <= 1'b0;
            ext_clk_d_ff <= 1'b0;
        end else begin
            gate_d_ff <= gate_lvl;
            ext_clk_d_ff <= external_period_clock_in;
        end
    end
    assign gate_rise = gate_lvl && !gate_d_ff;

    assign osc_tick = osc_cnt_ff >= tick_limit(period_ff);
    assign pll_tick = pll_cnt_ff >= tick_limit(pll_period_ff);

    // oscillator restarts on the gate so it is phase locked to it
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_ff <= '0;
            pll_cnt_ff <= '0;
        end else begin
            osc_cnt_ff <= (osc_restart || osc_tick) ? '0 : osc_cnt_ff + 1'b1;
            pll_cnt_ff <= pll_tick ? '0 : pll_cnt_ff + 1'b1;
        end
    end

    always_comb begin
        unique case (ctrl_ff.timebase_select)
            TB_PLL: tick = pll_tick;
            TB_EXT_CLK: tick = external_period_clock_in && !ext_clk_d_ff;
            default: tick = osc_tick;
        endcase
    end

    // continuous mode looks at neither origin nor edge select
    assign run_req = ctrl_ff.enable && ctrl_ff.mode != MODE_EXT_WIDTH &&
        (ctrl_ff.trig_mode == TRIG_CONT ||
         (ctrl_ff.trig_mode == TRIG_LEVEL && gate_rise));
    assign keep_going = ctrl_ff.enable &&
        ctrl_ff.mode != MODE_EXT_WIDTH &&
        (ctrl_ff.trig_mode == TRIG_CONT ||
         (ctrl_ff.trig_mode == TRIG_LEVEL && gate_lvl));

    // ************************************************************
    // sequencing
    // ************************************************************
    logic [CNT_W-1:0] idx_ff, new_idx, last_idx, width_cnt_ff, nxt_width_cnt;
    logic align_seen_ff, start;

    assign last_idx = unit_last(ctrl_ff.mode, burst_ff, pat_len_ff);
    assign osc_restart = state_ff == S_IDLE && run_req &&
                         ctrl_ff.timebase_select == TB_OSC;

    always_comb begin
        nxt_state = state_ff;
        start = 1'b0;
        new_idx = '0;
        unique case (state_ff)
            S_IDLE: if (run_req) begin
                if (ctrl_ff.timebase_select == TB_OSC) begin
                    start = 1'b1;
                    nxt_state = S_RUN;
                end else begin
                    nxt_state = S_ALIGN;
                end
            end
            S_ALIGN: if (tick && align_seen_ff) begin
                start = 1'b1;
                nxt_state = S_RUN;
            end
            S_RUN: if (tick) begin
                if (idx_ff != last_idx) begin
                    start = 1'b1;
                    new_idx = idx_ff + 1'b1;
                end else if (keep_going) begin
                    start = 1'b1;
                end else begin
                    nxt_state = S_IDLE;
                end
            end
        endcase
    end

    // first tick after the gate is a partial period and is skipped
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;
            idx_ff <= '0;
            align_seen_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (start) idx_ff <= new_idx;
            align_seen_ff <= state_ff == S_ALIGN && (align_seen_ff || tick);
        end
    end

    assign nxt_width_cnt = start ? width_ff :
        (width_cnt_ff != '0) ? width_cnt_ff - 1'b1 : '0;

    // ************************************************************
    // outputs
    // ************************************************************
    logic pulse_ff, marker_ff, strobe_ff;

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            width_cnt_ff <= '0;
            marker_ff <= 1'b0;
        end else begin
            width_cnt_ff <= nxt_width_cnt;
            marker_ff <= start;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pulse_ff <= 1'b0;
        end else if (ctrl_ff.mode == MODE_EXT_WIDTH) begin
            pulse_ff <= gate_lvl;
        end else if (ctrl_ff.mode == MODE_PATTERN) begin
            if (start) begin
                pulse_ff <= pat_bits_ff[new_idx[IDX_W-1:0]];
            end else if (nxt_state == S_IDLE) begin
                pulse_ff <= 1'b0;
            end
        end else begin
            pulse_ff <= nxt_width_cnt != '0;
        end
    end

    // strobe held for the whole bit period: nrz
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            strobe_ff <= 1'b0;
        end else if (start && ctrl_ff.mode == MODE_PATTERN) begin
            strobe_ff <= strobe_bits_ff[new_idx[IDX_W-1:0]];
        end else if (start && ctrl_ff.mode == MODE_BURST) begin
            strobe_ff <= new_idx != last_idx;
        end else if (nxt_state == S_IDLE ||
                     ctrl_ff.mode == MODE_PULSE ||
                     ctrl_ff.mode == MODE_EXT_WIDTH) begin
            strobe_ff <= 1'b0;
        end
    end

    assign pulse_out = pulse_ff;
    assign trig_marker_out = marker_ff;
    assign strobe_out = strobe_ff;
    assign rd_data_out = rd_data_ff;
    assign bus_primary_address_out = active_addr_ff;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n);

    sequence s_gate_seen_slow;
        state_ff == S_IDLE && nxt_state == S_ALIGN;
    endsequence
    // second timebase tick while aligning: the first full period
    sequence s_second_tick;
        state_ff == S_ALIGN && align_seen_ff && tick;
    endsequence

    a_manual_level_reject: assert property (
        wr_ctrl && wr_ctrl_val.trig_mode == TRIG_LEVEL &&
        wr_ctrl_val.arming_origin_select == ORG_MANUAL
        |=> cfg_err_ff && $stable(ctrl_ff))
        else $error("manual level arming accepted");
    a_pulse_pll_reject: assert property (
        !(ctrl_ff.mode == MODE_PULSE &&
          ctrl_ff.arming_origin_select == ORG_PLL))
        else $error("pulse mode holds pll origin");
    a_pll_twice_reject: assert property (
        !(ctrl_ff.arming_origin_select == ORG_PLL &&
          ctrl_ff.timebase_select == TB_PLL))
        else $error("pll used for origin and timebase");
    a_gate_start_osc: assert property (
        osc_restart |=> marker_ff)
        else $error("no period after gate rise");
    a_align_window: assert property (
        s_gate_seen_slow |=> !marker_ff && !align_seen_ff)
        else $error("period started before alignment");
    a_align_start: assert property (
        s_second_tick |=> marker_ff && state_ff == S_RUN)
        else $error("no period at second tick");
    a_align_no_early: assert property (
        state_ff == S_ALIGN && !(tick && align_seen_ff) |=> !marker_ff)
        else $error("marker during alignment");
    a_marker_single: assert property (
        marker_ff |=> !marker_ff || $past(tick))
        else $error("marker longer than one cycle without tick");
    a_ext_width_follow: assert property (
        ctrl_ff.mode == MODE_EXT_WIDTH && $stable(ctrl_ff)
        |=> pulse_ff == $past(gate_lvl))
        else $error("external width output not following gate");
    a_pattern_nrz: assert property (
        marker_ff && ctrl_ff.mode == MODE_PATTERN && $stable(ctrl_ff)
        |-> strobe_ff == strobe_bits_ff[idx_ff[IDX_W-1:0]])
        else $error("pattern strobe bit mismatch");
    a_burst_strobe: assert property (
        marker_ff && idx_ff == '0 && ctrl_ff.mode == MODE_BURST &&
        last_idx != '0 && $stable(ctrl_ff) |-> strobe_ff)
        else $error("burst strobe low at first period");
    a_no_truncate: assert property (
        state_ff == S_RUN && tick && idx_ff != last_idx
        |=> state_ff == S_RUN && marker_ff)
        else $error("unit cut short");
    a_addr_restart: assert property (
        active_addr_ff != $past(active_addr_ff)
        |-> $past(restart) && active_addr_ff <= ADDR_MAX)
        else $error("bus address changed without restart");
endmodule

// [seq_pkg.sv]
/*
 * Shared constants and types for the gated pulse/pattern sequencer:
 * register offsets, field layouts, reset values and mode encodings.
 * Assumes a byte-addressed register port with 32-bit words.
 */
package seq_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PERIOD = 8'h04;
    localparam logic [7:0] OFS_PLL_PERIOD = 8'h08;
    localparam logic [7:0] OFS_WIDTH = 8'h0C;
    localparam logic [7:0] OFS_BURST = 8'h10;
    localparam logic [7:0] OFS_PAT_LEN = 8'h14;
    localparam logic [7:0] OFS_PAT_BITS = 8'h18;
    localparam logic [7:0] OFS_STROBE_BITS = 8'h1C;
    localparam logic [7:0] OFS_ADDR = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_RESTART = 8'h28;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int CTRL_W = 11;
    localparam int ST_CFG_ERR = 0;
    localparam int ST_ADDR_ERR = 1;
    localparam int ST_RUNNING = 2;
    localparam int ST_GATE = 3;
    localparam int ADDR_ACTIVE_LSB = 8;
    localparam int RESTART_BIT = 0;
    localparam logic [4:0] ADDR_MAX = 5'h1E;
    localparam logic [4:0] ADDR_DEFAULT = 5'h0A;
    localparam logic [15:0] PERIOD_RESET = 16'h0028;
    localparam logic [15:0] WIDTH_RESET = 16'h0014;
    localparam logic [15:0] BURST_RESET = 16'h0002;
    localparam logic [15:0] PAT_LEN_RESET = 16'h0003;

    // ************************************************************
    // modes and selections
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_PULSE, MODE_BURST, MODE_PATTERN, MODE_EXT_WIDTH
    } mode_type;
    typedef enum logic [1:0] {TRIG_CONT, TRIG_EDGE, TRIG_LEVEL} trig_type;
    typedef enum logic [1:0] {ORG_EXT, ORG_PLL, ORG_MANUAL} origin_type;
    typedef enum logic [1:0] {TB_OSC, TB_PLL, TB_EXT_CLK} timebase_type;

    typedef struct packed {
        logic [1:0] active_edge_select;
        timebase_type timebase_select;
        origin_type arming_origin_select;
        trig_type trig_mode;
        mode_type mode;
        logic enable;
    } ctrl_type;

    localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;

endpackage

// [gate_synchronizer.sv]
/*
 * Two-stage level synchronizer for the asynchronous gate input.
 * Assumes the reset given is already synchronous on release.
 */
`timescale 1ns/1ps
module gate_synchronizer (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1_ff;
    logic stage2_ff;

    // first stage is read by the second stage only
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_out = stage2_ff;
endmodule

// [gate_source.sv]
/* far-side model: asynchronous gate source and external timebase.
   assumes clk_in is the system clock of the sequencer. */
`timescale 1ns/1ps
module gate_source #(parameter int TICK = 6) (
    input wire logic clk_in,
    output logic gate_out,
    output logic ext_clk_out
);
    int cnt = 0;
    initial gate_out = 1'b0;
    initial ext_clk_out = 1'b0;
    // free-running timebase, one tick every TICK cycles
    always @(posedge clk_in) begin
        cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
        ext_clk_out <= (cnt == 0);
    end
    // off the clock grid on purpose: the gate is asynchronous
    task automatic pulse(input int n);
        @(posedge clk_in);
        #7 gate_out = 1'b1;
        repeat (n) @(posedge clk_in);
        #7 gate_out = 1'b0;
    endtask
endmodule

// [testbench.sv]
/* self-checking bench for pulse_sequencer with a marker-count model.
   assumes gate_source.sv as the far side of the gate and timebase. */
`timescale 1ns/1ps
module testbench;
    import seq_pkg::*;
    logic clk, rst_n, ws, rs, gate, eclk, pout, mark, strb;
    logic [7:0] addr;
    logic [31:0] wd, rdo, rdv, pat, stb;
    logic [4:0] bpa;
    int miscompares = 0, n_checks = 0, cyc = 0, seed = 19654;
    int u = 1, md = 0, nm = 0, first = 0, t0 = 0;
    int bad[3] = '{83, 41, 171};
    pulse_sequencer uut (.sys_clk_in(clk), .reset_n_in(rst_n),
        .addr_in(addr), .wr_data_in(wd), .wr_strobe_in(ws),
        .rd_strobe_in(rs), .rd_data_out(rdo),
        .external_gate_input_in(gate), .external_period_clock_in(eclk),
        .pulse_out(pout), .trig_marker_out(mark), .strobe_out(strb),
        .bus_primary_address_out(bpa));
    gate_source #(.TICK(6)) gsrc (.clk_in(clk), .gate_out(gate),
        .ext_clk_out(eclk));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        ws <= 1'b1;
        @(posedge clk);
        ws <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rs <= 1'b1;
        @(posedge clk);
        rs <= 1'b0;
        #1 rdv = rdo;
    endtask
    // model: unit position follows from the marker count
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            finish_test();
        end
        if (mark === 1'b1) begin
            if (nm == 0) first = cyc - t0;
            if (md == 2) begin
                chk("pattern bit", 32'(pat[nm % u]), 32'(pout));
                chk("strobe bit", 32'(stb[nm % u]), 32'(strb));
            end else chk("pulse level", 1, 32'(pout));
            if (md == 1 && nm % u == 0)
                chk("strobe first", 1, 32'(strb));
            if (md == 1 && nm % u == u - 1)
                chk("strobe last", 0, 32'(strb));
            nm++;
        end
    end
    task automatic run(input int m, tb, n, g);
        md = m;
        u = n;
        nm = 0;
        wr(OFS_CTRL, 32'(tb * 128 + 16 + m * 2 + 1));
        t0 = cyc;
        gsrc.pulse(g);
        rdv = 32'h4;
        for (int i = 0; i < 200 && rdv[ST_RUNNING] !== 1'b0; i++)
            rd(OFS_STATUS);
        chk("running", 0, 32'(rdv[ST_RUNNING]));
        wr(OFS_CTRL, 0);
    endtask
    initial begin
        rst_n = 1'b0;
        ws = 1'b0;
        rs = 1'b0;
        addr = 8'h00;
        wd = 32'h0;
        pat = $random(seed);
        stb = $random(seed);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk("address reset", 10, 32'(bpa));
        wr(OFS_ADDR, 31);
        rd(OFS_STATUS);
        chk("address refused", 2, rdv & 2);
        wr(OFS_ADDR, 30);
        wr(OFS_STATUS, 3);
        chk("address held", 10, 32'(bpa));
        wr(OFS_RESTART, 1);
        chk("address live", 30, 32'(bpa));
        foreach (bad[i]) begin
            wr(OFS_CTRL, bad[i]);
            rd(OFS_CTRL);
            chk("ctrl kept", 0, rdv);
            rd(OFS_STATUS);
            chk("cfg error", 1, rdv & 1);
            wr(OFS_STATUS, 3);
        end
        rd(8'hFC);
        chk("unmapped", 0, rdv);
        wr(OFS_PERIOD, 4);
        wr(OFS_WIDTH, 2);
        wr(OFS_BURST, 3);
        wr(OFS_PAT_LEN, 5);
        wr(OFS_PAT_BITS, pat);
        wr(OFS_STROBE_BITS, stb);
        run(0, 0, 1, 15);
        chk("pulse count", 4, nm);
        chk("pulse start", 1, 32'(first <= 7));
        run(1, 0, 3, 31);
        chk("burst count", 9, nm);
        run(2, 0, 5, 31);
        chk("pattern count", 10, nm);
        run(2, 2, 5, 40);
        chk("whole patterns", 1, 32'(nm > 0 && nm % 5 == 0));
        chk("clock delay", 1, 32'(first >= 11 && first <= 18));
        wr(OFS_PLL_PERIOD, 5);
        run(1, 1, 3, 20);
        chk("pll burst", 3, nm);
        chk("pll delay", 1, 32'(first >= 11 && first <= 15));
        // continuous: manual origin and edge select must not matter
        md = 0;
        nm = 0;
        wr(OFS_CTRL, 1089);
        repeat (20) @(posedge clk);
        wr(OFS_CTRL, 0);
        chk("continuous", 6, nm);
        wr(OFS_CTRL, 23);
        fork
            gsrc.pulse(20);
        join_none
        repeat (10) @(posedge clk);
        chk("width high", 1, 32'(pout));
        repeat (20) @(posedge clk);
        chk("width low", 0, 32'(pout));
        finish_test();
    end
endmodule
